/* rtl/cticg_pkg.sv */
/*
 Constants for the second-channel input and gain setup registers.
 Assumes one 40 MHz clock and a byte-wide register port from the host side.
*/
// Notes on behaviour
// R01: setup bit 7 picks microphone or line
// R02: setup bits 6-5 pick input source
// R03: host frees shared pins before analog source
// R04: host routes mic data and clock pins
// R05: setup bit 4 couples AC or DC, analog
// R06: setup bits 3-2 pick input impedance
// R07: setup bit 1 reserved, reads zero
// R08: setup bit 0 enables enhancer, mode-selected
// R09: gain bits 7-1, half-dB, max code 84
// R10: gain bit 0 sign, limited negative range
// R11: offsets 0x41..0x43, resets zero and 0xc9
// R12: eight-bit registers read back last write
package cticg_pkg;
	localparam logic [7:0] OFS_INPUT_SETUP = 8'h41;
	localparam logic [7:0] OFS_GAIN_SETUP = 8'h42;
	localparam logic [7:0] OFS_VOLUME_SETUP = 8'h43;
	localparam logic [7:0] RST_INPUT_SETUP = 8'h00;
	localparam logic [7:0] RST_GAIN_SETUP = 8'h00;
	localparam logic [7:0] RST_VOLUME_SETUP = 8'hc9;
	localparam logic [7:0] INPUT_SETUP_WMASK = 8'hfd;
	localparam int POS_KIND = 7;
	localparam int POS_SRC_HI = 6;
	localparam int POS_SRC_LO = 5;
	localparam int POS_COUPLING = 4;
	localparam int POS_IMP_HI = 3;
	localparam int POS_IMP_LO = 2;
	localparam int POS_RESERVED = 1;
	localparam int POS_ENH = 0;
	localparam int POS_GAIN_HI = 7;
	localparam int POS_GAIN_LO = 1;
	localparam int POS_SIGN = 0;
	localparam logic [6:0] GAIN_MAX_CODE = 7'h54;
	localparam logic [6:0] GAIN_NEG_MAX_CODE = 7'h16;
	typedef enum logic [1:0] {
		CTICG_SRC_ANA_DIFF = 2'b00,
		CTICG_SRC_ANA_SE = 2'b01,
		CTICG_SRC_PDM = 2'b10,
		CTICG_SRC_RSVD = 2'b11
	} cticg_src_e;
	typedef enum logic [1:0] {
		CTICG_IMP_2K5 = 2'b00,
		CTICG_IMP_10K = 2'b01,
		CTICG_IMP_20K = 2'b10,
		CTICG_IMP_RSVD = 2'b11
	} cticg_imp_e;
endpackage

/* rtl/cticg_regs.sv */
/*
 Second-channel input and gain setup register bank with decoded,
 sanitised control outputs for the analog front end.
 Assumes the register port and the enhancer mode bit come from logic
 on the same clock; pin routing is set up by the host beforehand.
*/
`timescale 1ns/1ps
`default_nettype none
module cticg_regs (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_enhancer_mode_sel,
	output logic [7:0] o_rdata,
	output logic o_rd_valid,
	output logic o_second_input_kind,
	output logic [1:0] o_second_input_source,
	output logic o_second_input_analog,
	output logic o_second_input_coupling,
	output logic [1:0] o_second_input_impedance,
	output logic o_second_enhancer_enable,
	output logic o_range_enhancer_on,
	output logic o_auto_level_control_on,
	output logic [6:0] o_second_channel_gain,
	output logic o_second_gain_polarity,
	output logic [7:0] o_second_volume,
	output logic o_setup_fault
);
	// ==================================================
	// Register file
	logic [7:0] input_setup_reg, input_setup_next;
	logic [7:0] gain_setup_reg, gain_setup_next;
	logic [7:0] volume_setup_reg, volume_setup_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rd_valid_reg, rd_valid_next;

	always_comb begin
		input_setup_next = input_setup_reg;
		gain_setup_next = gain_setup_reg;
		volume_setup_next = volume_setup_reg;
		if (i_wr_en) begin
			case (i_addr)
				// Reserved bit forced low so it always reads zero [R07]
				cticg_pkg::OFS_INPUT_SETUP: begin
					input_setup_next = i_wdata & cticg_pkg::INPUT_SETUP_WMASK; // [R11]
				end
				cticg_pkg::OFS_GAIN_SETUP: begin
					gain_setup_next = i_wdata; // [R11]
				end
				cticg_pkg::OFS_VOLUME_SETUP: begin
					volume_setup_next = i_wdata; // [R11]
				end
				default: begin
					input_setup_next = input_setup_reg;
				end
			endcase
		end
	end

	// Reads see the stored value, so a same-cycle write shows next read [R12]
	always_comb begin
		rd_valid_next = i_rd_en;
		rdata_next = 8'h00;
		if (i_rd_en) begin
			case (i_addr)
				cticg_pkg::OFS_INPUT_SETUP: rdata_next = input_setup_reg;
				cticg_pkg::OFS_GAIN_SETUP: rdata_next = gain_setup_reg;
				cticg_pkg::OFS_VOLUME_SETUP: rdata_next = volume_setup_reg;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			input_setup_reg <= cticg_pkg::RST_INPUT_SETUP; // [R11]
			gain_setup_reg <= cticg_pkg::RST_GAIN_SETUP;
			volume_setup_reg <= cticg_pkg::RST_VOLUME_SETUP;
		end else begin
			input_setup_reg <= input_setup_next;
			gain_setup_reg <= gain_setup_next;
			volume_setup_reg <= volume_setup_next;
		end
	end

	// Read answer stands one cycle only, then drops back to zero
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rdata_reg <= 8'h00;
			rd_valid_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			rd_valid_reg <= rd_valid_next;
		end
	end

	// ==================================================
	// Field decode
	// Outputs lag the register by one cycle so each one leaves a flip-flop.
	logic [1:0] src;
	logic [1:0] imp;
	logic [6:0] gain_raw;
	logic analog;
	logic neg_ok;
	logic kind_next, analog_next, coupling_next, enh_next;
	logic dre_next, agc_next, pol_next, fault_next;
	logic [1:0] src_next, imp_next;
	logic [6:0] gain_next;
	logic kind_reg, analog_reg, coupling_reg, enh_reg;
	logic dre_reg, agc_reg, pol_reg, fault_reg;
	logic [1:0] src_reg, imp_reg;
	logic [6:0] gain_reg;
	logic [7:0] vol_reg;

	always_comb begin
		src = input_setup_reg[cticg_pkg::POS_SRC_HI:cticg_pkg::POS_SRC_LO];
		imp = input_setup_reg[cticg_pkg::POS_IMP_HI:cticg_pkg::POS_IMP_LO];
		gain_raw = gain_setup_reg[cticg_pkg::POS_GAIN_HI:cticg_pkg::POS_GAIN_LO];
		kind_next = input_setup_reg[cticg_pkg::POS_KIND]; // [R01]
		src_next = src; // [R02]
		analog = (src == cticg_pkg::CTICG_SRC_ANA_DIFF) || (src == cticg_pkg::CTICG_SRC_ANA_SE);
		analog_next = analog;
		// Coupling has no meaning for the digital microphone path [R05]
		coupling_next = analog & input_setup_reg[cticg_pkg::POS_COUPLING];
		imp_next = imp; // [R06]
		enh_next = input_setup_reg[cticg_pkg::POS_ENH]; // [R08]
		dre_next = enh_next & ~i_enhancer_mode_sel; // [R08]
		agc_next = enh_next & i_enhancer_mode_sel; // [R08]
		neg_ok = (imp == cticg_pkg::CTICG_IMP_10K) || (imp == cticg_pkg::CTICG_IMP_20K);
		// Negative sign ignored at the low impedance, which cannot serve it [R10]
		pol_next = gain_setup_reg[cticg_pkg::POS_SIGN] & neg_ok;
		// Reserved gain codes saturate rather than reach the amplifier [R09]
		gain_next = (gain_raw > cticg_pkg::GAIN_MAX_CODE) ? cticg_pkg::GAIN_MAX_CODE : gain_raw;
		if (pol_next && gain_next > cticg_pkg::GAIN_NEG_MAX_CODE) begin
			gain_next = cticg_pkg::GAIN_NEG_MAX_CODE; // [R10]
		end
		fault_next = (src == cticg_pkg::CTICG_SRC_RSVD) || (imp == cticg_pkg::CTICG_IMP_RSVD)
			|| (gain_raw > cticg_pkg::GAIN_MAX_CODE)
			|| (gain_setup_reg[cticg_pkg::POS_SIGN] && !neg_ok)
			|| (gain_setup_reg[cticg_pkg::POS_SIGN]
				&& gain_raw > cticg_pkg::GAIN_NEG_MAX_CODE);
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			kind_reg <= 1'b0;
			src_reg <= 2'h0;
			// Source zero after reset is the analog differential input
			analog_reg <= 1'b1;
			coupling_reg <= 1'b0;
			imp_reg <= 2'h0;
			enh_reg <= 1'b0;
			dre_reg <= 1'b0;
			agc_reg <= 1'b0;
			gain_reg <= 7'h00;
			pol_reg <= 1'b0;
			vol_reg <= cticg_pkg::RST_VOLUME_SETUP;
			fault_reg <= 1'b0;
		end else begin
			kind_reg <= kind_next;
			src_reg <= src_next;
			analog_reg <= analog_next;
			coupling_reg <= coupling_next;
			imp_reg <= imp_next;
			enh_reg <= enh_next;
			dre_reg <= dre_next;
			agc_reg <= agc_next;
			gain_reg <= gain_next;
			pol_reg <= pol_next;
			vol_reg <= volume_setup_reg;
			fault_reg <= fault_next;
		end
	end

	// ==================================================
	// Outputs
	// Every output leaves a flop, so the front end never sees a decode glitch
	assign o_rdata = rdata_reg;
	assign o_rd_valid = rd_valid_reg;
	assign o_second_input_kind = kind_reg;
	assign o_second_input_source = src_reg;
	assign o_second_input_analog = analog_reg;
	assign o_second_input_coupling = coupling_reg;
	assign o_second_input_impedance = imp_reg;
	assign o_second_enhancer_enable = enh_reg;
	assign o_range_enhancer_on = dre_reg;
	assign o_auto_level_control_on = agc_reg;
	assign o_second_channel_gain = gain_reg;
	assign o_second_gain_polarity = pol_reg;
	assign o_second_volume = vol_reg;
	assign o_setup_fault = fault_reg;

	// ==================================================
	// Checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);

	// Decoded fields follow a write two edges later: register, then output flop
	kind_follows_a: assert property ( // [R01]
		i_wr_en && !i_rd_en && i_addr == cticg_pkg::OFS_INPUT_SETUP
		|=> ##1 o_second_input_kind == $past(i_wdata[7], 2))
		else $error("input kind not taken from bit 7");

	source_follows_a: assert property ( // [R02]
		i_wr_en && i_addr == cticg_pkg::OFS_INPUT_SETUP
		|=> ##1 o_second_input_source == $past(i_wdata[6:5], 2))
		else $error("source not taken from bits 6-5");

	analog_flag_a: assert property ( // [R02]
		o_second_input_analog == (o_second_input_source inside {2'b00, 2'b01}))
		else $error("analog flag disagrees with source");

	fault_source_a: assert property ( // [R02]
		o_second_input_source == 2'b11 |-> o_setup_fault)
		else $error("reserved source not flagged");

	coupling_follows_a: assert property ( // [R05]
		i_wr_en && i_addr == cticg_pkg::OFS_INPUT_SETUP
		&& i_wdata[6:5] inside {2'b00, 2'b01}
		|=> ##1 o_second_input_coupling == $past(i_wdata[4], 2))
		else $error("coupling not taken from bit 4");

	coupling_analog_a: assert property ( // [R05]
		o_second_input_coupling |-> o_second_input_source inside {2'b00, 2'b01})
		else $error("coupling set on digital source");

	impedance_follows_a: assert property ( // [R06]
		i_wr_en && i_addr == cticg_pkg::OFS_INPUT_SETUP
		|=> ##1 o_second_input_impedance == $past(i_wdata[3:2], 2))
		else $error("impedance not taken from bits 3-2");

	// Bit 1 must never hold a one, whatever software writes
	reserved_zero_a: assert property ( // [R07]
		o_rd_valid && $past(i_addr) == cticg_pkg::OFS_INPUT_SETUP |-> o_rdata[1] == 1'b0)
		else $error("reserved bit read as one");

	reserved_store_a: assert property ( // [R07]
		input_setup_reg[cticg_pkg::POS_RESERVED] == 1'b0)
		else $error("reserved bit stored as one");

	enhancer_follows_a: assert property ( // [R08]
		i_wr_en && i_addr == cticg_pkg::OFS_INPUT_SETUP
		|=> ##1 o_second_enhancer_enable == $past(i_wdata[0], 2))
		else $error("enhancer enable not taken from bit 0");

	enhancer_mode_a: assert property ( // [R08]
		!(o_range_enhancer_on && o_auto_level_control_on)
		&& ((o_range_enhancer_on || o_auto_level_control_on) == o_second_enhancer_enable))
		else $error("enhancer mode selection broken");

	// Clamps keep reserved and unsupported settings away from the amplifier
	gain_follows_a: assert property ( // [R09]
		i_wr_en && i_addr == cticg_pkg::OFS_GAIN_SETUP && !i_wdata[0]
		&& i_wdata[7:1] <= cticg_pkg::GAIN_MAX_CODE
		|=> ##1 o_second_channel_gain == $past(i_wdata[7:1], 2))
		else $error("positive gain code not passed through");

	gain_limit_a: assert property ( // [R09]
		o_second_channel_gain <= cticg_pkg::GAIN_MAX_CODE)
		else $error("gain above top code");

	negative_gain_a: assert property ( // [R10]
		o_second_gain_polarity
		|-> o_second_channel_gain <= cticg_pkg::GAIN_NEG_MAX_CODE
		&& o_second_input_impedance inside {2'b01, 2'b10})
		else $error("negative gain out of range");

	low_impedance_sign_a: assert property ( // [R10]
		o_second_input_impedance == 2'b00 |-> !o_second_gain_polarity)
		else $error("negative gain at low impedance");

	// ==================================================
	// Register port checks
	reset_values_a: assert property ( // [R11]
		$rose(i_arst_n) |-> o_second_volume == 8'hc9)
		else $error("volume reset value wrong");

	unmapped_read_a: assert property ( // [R11]
		i_rd_en && i_addr != cticg_pkg::OFS_INPUT_SETUP
		&& i_addr != cticg_pkg::OFS_GAIN_SETUP && i_addr != cticg_pkg::OFS_VOLUME_SETUP
		|=> o_rdata == 8'h00)
		else $error("unmapped offset answered");

	readback_a: assert property ( // [R12]
		i_wr_en && i_addr == cticg_pkg::OFS_GAIN_SETUP
		##1 (i_rd_en && !i_wr_en && i_addr == cticg_pkg::OFS_GAIN_SETUP)
		|=> o_rd_valid && o_rdata == $past(i_wdata, 2))
		else $error("gain setup read back wrong");

	volume_follows_a: assert property ( // [R12]
		i_wr_en && i_addr == cticg_pkg::OFS_VOLUME_SETUP
		|=> ##1 o_second_volume == $past(i_wdata, 2))
		else $error("volume not copied from its register");

	read_strobe_a: assert property ( // [R12]
		i_rd_en |=> o_rd_valid)
		else $error("read not answered after one cycle");

	read_idle_a: assert property ( // [R12]
		!i_rd_en |=> !o_rd_valid && o_rdata == 8'h00)
		else $error("read answer stands too long");

	// Main scenarios the bench is expected to reach
	pdm_cover_c: cover property (o_second_input_source == 2'b10 && o_second_enhancer_enable);
	neg_gain_cover_c: cover property (o_second_gain_polarity && o_second_channel_gain != 7'h00);
	fault_cover_c: cover property (o_setup_fault);
	readback_cover_c: cover property (o_rd_valid && o_rdata == 8'hc9);
	analog_dc_cover_c: cover property (o_second_input_analog && o_second_input_coupling);
endmodule
`default_nettype wire

/* testbench/tb.sv */
/*
 Self-checking bench for the second-channel setup register bank.
 Assumes a same-clock strobe port and decoded outputs two edges after a write.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct {logic [7:0] s; logic [7:0] g; logic [7:0] v; logic m;} cticg_row_s;
	logic i_clock = 1'b0;
	logic i_arst_n = 1'b0;
	logic i_wr_en = 1'b0;
	logic i_rd_en = 1'b0;
	logic i_enhancer_mode_sel = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic [7:0] o_rdata, o_second_volume;
	logic o_rd_valid, o_second_input_kind, o_second_input_analog, o_second_input_coupling;
	logic o_second_enhancer_enable, o_range_enhancer_on, o_auto_level_control_on;
	logic o_second_gain_polarity, o_setup_fault;
	logic [1:0] o_second_input_source, o_second_input_impedance;
	logic [6:0] o_second_channel_gain;
	logic [26:0] dec;
	int n_errors = 0;
	int comparisons = 0;
	int cyc = 0;
	// Covers every source, impedance, gain saturation and sign corner
	cticg_row_s rows [6] = '{'{8'he5, 8'h29, 8'h01, 1'b0}, '{8'h9b, 8'hab, 8'h00, 1'b1},
		'{8'h30, 8'h01, 8'hff, 1'b0}, '{8'h55, 8'ha8, 8'hc8, 1'b1},
		'{8'h0e, 8'hfe, 8'h80, 1'b0}, '{8'h09, 8'h2d, 8'h7f, 1'b1}};
	cticg_regs dut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_wr_en(i_wr_en),
		.i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_enhancer_mode_sel(i_enhancer_mode_sel), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
		.o_second_input_kind(o_second_input_kind), .o_second_input_source(o_second_input_source),
		.o_second_input_analog(o_second_input_analog),
		.o_second_input_coupling(o_second_input_coupling),
		.o_second_input_impedance(o_second_input_impedance),
		.o_second_enhancer_enable(o_second_enhancer_enable),
		.o_range_enhancer_on(o_range_enhancer_on),
		.o_auto_level_control_on(o_auto_level_control_on),
		.o_second_channel_gain(o_second_channel_gain),
		.o_second_gain_polarity(o_second_gain_polarity), .o_second_volume(o_second_volume),
		.o_setup_fault(o_setup_fault));
	assign dec = {o_second_input_kind, o_second_input_source, o_second_input_analog,
		o_second_input_coupling, o_second_input_impedance, o_second_enhancer_enable,
		o_range_enhancer_on, o_auto_level_control_on, o_second_channel_gain,
		o_second_gain_polarity, o_second_volume, o_setup_fault};
	// ==================================================
	// Expected decode
	function automatic logic [26:0] exp_dec(input logic [7:0] s, g, v, input logic m);
		logic ana, neg, flt;
		logic [6:0] gc, eg;
		logic [1:0] imp;
		imp = s[3:2];
		ana = s[6:5] < 2'h2;
		gc = g[7:1];
		neg = g[0] && (imp == 2'h1 || imp == 2'h2);
		eg = (gc > 7'h54) ? 7'h54 : gc;
		if (neg && eg > 7'h16) begin
			eg = 7'h16;
		end
		flt = s[6:5] == 2'h3 || imp == 2'h3 || gc > 7'h54 || (g[0] && !neg) || (g[0] && gc > 7'h16);
		return {s[7], s[6:5], ana, s[4] & ana, imp, s[0], s[0] & !m, s[0] & m, eg, neg, v, flt};
	endfunction
	// ==================================================
	// Port tasks, entered and left just after a rising edge
	task automatic chk(input logic [26:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		i_wr_en <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr_en <= 1'b0;
		@(posedge i_clock);
	endtask
	task automatic rd(input logic [7:0] a, e);
		i_rd_en <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd_en <= 1'b0;
		#1 chk(27'({o_rd_valid, o_rdata}), 27'({1'b1, e}));
		@(posedge i_clock);
		#1 chk(27'({o_rd_valid, o_rdata}), 27'h0000000);
		@(posedge i_clock);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ==================================================
	// Clock and hang guard
	initial begin
		forever #12.5 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	// ==================================================
	// Main sequence
	initial begin
		repeat (2) @(posedge i_clock);
		i_arst_n <= 1'b1;
		#1 chk(dec, exp_dec(8'h00, 8'h00, 8'hc9, 1'b0));
		@(posedge i_clock);
		rd(8'h41, 8'h00);
		rd(8'h42, 8'h00);
		rd(8'h43, 8'hc9);
		foreach (rows[i]) begin // Shared pins set up by host per source
			i_enhancer_mode_sel <= rows[i].m;
			wr(8'h41, rows[i].s);
			wr(8'h42, rows[i].g);
			wr(8'h43, rows[i].v);
			#1 chk(dec, exp_dec(rows[i].s, rows[i].g, rows[i].v, rows[i].m));
			@(posedge i_clock);
			rd(8'h41, rows[i].s & 8'hfd);
			rd(8'h42, rows[i].g);
			rd(8'h43, rows[i].v);
		end
		// Neighbouring offsets must neither store nor answer
		wr(8'h44, 8'hff);
		wr(8'h40, 8'hff);
		rd(8'h40, 8'h00);
		rd(8'h44, 8'h00);
		rd(8'h41, 8'h09);
		rd(8'h43, 8'h7f);
		// Back-to-back writes; the read beside the first write sees the old byte
		i_wr_en <= 1'b1;
		i_rd_en <= 1'b1;
		i_addr <= 8'h42;
		i_wdata <= 8'h55;
		@(posedge i_clock);
		i_rd_en <= 1'b0;
		i_addr <= 8'h43;
		i_wdata <= 8'h12;
		#1 chk(27'({o_rd_valid, o_rdata}), 27'({1'b1, 8'h2d}));
		@(posedge i_clock);
		i_wr_en <= 1'b0;
		@(posedge i_clock);
		rd(8'h42, 8'h55);
		rd(8'h43, 8'h12);
		// Read straight after a write sees the new byte
		i_wr_en <= 1'b1;
		i_addr <= 8'h42;
		i_wdata <= 8'h66;
		@(posedge i_clock);
		i_wr_en <= 1'b0;
		i_rd_en <= 1'b1;
		@(posedge i_clock);
		i_rd_en <= 1'b0;
		#1 chk(27'({o_rd_valid, o_rdata}), 27'({1'b1, 8'h66}));
		@(posedge i_clock);
		// Reset in mid-run restores every register
		i_arst_n <= 1'b0;
		@(posedge i_clock);
		#1 chk(dec, exp_dec(8'h00, 8'h00, 8'hc9, 1'b1));
		@(posedge i_clock);
		i_arst_n <= 1'b1;
		@(posedge i_clock);
		rd(8'h41, 8'h00);
		rd(8'h42, 8'h00);
		rd(8'h43, 8'hc9);
		tally_and_finish();
	end
endmodule
`default_nettype wire
